// ===== verilog/test_config_version_regs.sv
/*
 * Test-page register bank: self-test control, silicon version and aux
 * pin source select, with the type B frame marker generator and the
 * receive threshold shaping that the control bits steer.
 * Assumes a plain register port on i_clock, one-cycle strobes, and
 * marker start requests as one-cycle pulses from the same clock.
 */
`timescale 1ns/1ps
module test_config_version_regs
#(
	parameter int ETU_CYCLES = test_regs_pkg::ETU_CYCLES_DEFAULT,
	parameter logic [7:0] VERSION_CODE = 8'h5A // arbitrary value
)
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire test_regs_pkg::reg_req_t i_reg_req,
	output logic [7:0] o_rd_data,
	input wire logic i_frame_marker_width_select,
	input wire logic i_start_sof,
	input wire logic i_start_eof,
	input wire logic i_checksum_compute_command,
	input wire logic [3:0] i_min_signal_level,
	input wire logic [2:0] i_collision_level,
	output logic o_receiver_nonlinear_gain,
	output logic [7:0] o_min_threshold,
	output logic [7:0] o_collision_threshold,
	output logic o_marker_busy,
	output logic o_marker_level,
	output logic o_self_test_enable,
	output logic o_self_test_start,
	output logic [3:0] o_aux_one_source_select,
	output logic [3:0] o_aux_two_source_select
);
	localparam int CW = test_regs_pkg::PHASE_COUNT_WIDTH;

	if (ETU_CYCLES <= test_regs_pkg::ADJUST_CYCLES ||
		ETU_CYCLES * test_regs_pkg::SOF_LOW_MAX_ETU >= (1 << CW))
	begin
		$error("ETU_CYCLES out of range for the phase counter");
	end

	// ----------------------------------------------------------------
	// phase lengths in clock cycles
	// ----------------------------------------------------------------
	localparam logic [CW-1:0] LOW_MIN_LEN = CW'(ETU_CYCLES * test_regs_pkg::SOF_LOW_MIN_ETU);
	localparam logic [CW-1:0] LOW_MAX_LEN = CW'(ETU_CYCLES * test_regs_pkg::SOF_LOW_MAX_ETU);
	localparam logic [CW-1:0] LOW_ADJ_LEN =
		CW'(ETU_CYCLES * test_regs_pkg::SOF_LOW_MAX_ETU - test_regs_pkg::ADJUST_CYCLES);
	localparam logic [CW-1:0] HIGH_MIN_LEN = CW'(ETU_CYCLES * test_regs_pkg::SOF_HIGH_MIN_ETU);
	localparam logic [CW-1:0] HIGH_MAX_LEN = CW'(ETU_CYCLES * test_regs_pkg::SOF_HIGH_MAX_ETU);
	localparam logic [CW-1:0] HIGH_ADJ_LEN =
		CW'(ETU_CYCLES * test_regs_pkg::SOF_HIGH_MIN_ETU + test_regs_pkg::ADJUST_CYCLES);

	typedef enum logic [1:0] {MK_IDLE, MK_SOF_LOW, MK_SOF_HIGH, MK_EOF_LOW} marker_state_t;

	test_regs_pkg::self_test_control_t ctrl_ff;
	test_regs_pkg::aux_select_t aux_ff;
	logic [7:0] rd_data_ff;
	logic [7:0] nxt_rd_data;
	marker_state_t state_ff;
	marker_state_t nxt_state;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] phase_len;
	logic phase_end;
	logic adj_ff;
	logic wide_ff;
	logic level_ff;
	logic nxt_level;
	logic [CW-1:0] hold_ff;

	function automatic logic hit(input test_regs_pkg::reg_req_t r, input logic [7:0] off);
		return r.addr == off;
	endfunction

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			ctrl_ff <= test_regs_pkg::SELF_TEST_CONTROL_RESET;
		else if (i_reg_req.wr && hit(i_reg_req, test_regs_pkg::SELF_TEST_CONTROL_OFFSET))
		begin
			// reserved bits keep their reset value whatever is written
			ctrl_ff.reserved_hi <= test_regs_pkg::SELF_TEST_CONTROL_RESET[test_regs_pkg::RESERVED_HI_BIT];
			ctrl_ff.reserved_lo <= test_regs_pkg::SELF_TEST_CONTROL_RESET[test_regs_pkg::RESERVED_LO_BIT];
			ctrl_ff.receiver_nonlinear_gain <= i_reg_req.wdata[test_regs_pkg::GAIN_BIT];
			ctrl_ff.frame_marker_fine_adjust <= i_reg_req.wdata[test_regs_pkg::FINE_ADJUST_BIT];
			ctrl_ff.self_test_select <= i_reg_req.wdata[3:0];
		end
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			aux_ff <= test_regs_pkg::AUX_PIN_SOURCE_SELECT_RESET;
		else if (i_reg_req.wr && hit(i_reg_req, test_regs_pkg::AUX_PIN_SOURCE_SELECT_OFFSET))
			aux_ff <= i_reg_req.wdata;
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	// read data is zero outside the cycle after a read, so stale values never linger
	always_comb
	begin
		nxt_rd_data = 8'h00;
		if (i_reg_req.rd)
		begin
			case (i_reg_req.addr)
				test_regs_pkg::SELF_TEST_CONTROL_OFFSET: nxt_rd_data = ctrl_ff;
				test_regs_pkg::SILICON_VERSION_OFFSET: nxt_rd_data = VERSION_CODE;
				test_regs_pkg::AUX_PIN_SOURCE_SELECT_OFFSET: nxt_rd_data = aux_ff;
				default: nxt_rd_data = test_regs_pkg::UNMAPPED_READ_VALUE;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			rd_data_ff <= 8'h00;
		else
			rd_data_ff <= nxt_rd_data;
	end

	// ----------------------------------------------------------------
	// frame marker generator
	// ----------------------------------------------------------------
	// adjust with width off is undefined; it falls back to the minimum lengths
	always_comb
	begin
		phase_len = LOW_MIN_LEN;
		case (state_ff)
			MK_SOF_LOW, MK_EOF_LOW:
			begin
				if (adj_ff && wide_ff)
					phase_len = LOW_ADJ_LEN;
				else if (wide_ff)
					phase_len = LOW_MAX_LEN;
				else
					phase_len = LOW_MIN_LEN;
			end
			MK_SOF_HIGH:
			begin
				if (adj_ff && wide_ff)
					phase_len = HIGH_ADJ_LEN;
				else if (wide_ff)
					phase_len = HIGH_MAX_LEN;
				else
					phase_len = HIGH_MIN_LEN;
			end
			default: phase_len = LOW_MIN_LEN;
		endcase
	end

	assign phase_end = (cnt_ff == phase_len - CW'(1));

	// starts that arrive while a marker runs are dropped
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			MK_IDLE:
			begin
				if (i_start_sof)
					nxt_state = MK_SOF_LOW;
				else if (i_start_eof)
					nxt_state = MK_EOF_LOW;
			end
			MK_SOF_LOW: if (phase_end) nxt_state = MK_SOF_HIGH;
			MK_SOF_HIGH: if (phase_end) nxt_state = MK_IDLE;
			MK_EOF_LOW: if (phase_end) nxt_state = MK_IDLE;
			default: nxt_state = MK_IDLE;
		endcase
	end

	assign nxt_level = !(nxt_state == MK_SOF_LOW || nxt_state == MK_EOF_LOW);

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			state_ff <= MK_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			cnt_ff <= '0;
		else if (nxt_state != state_ff || state_ff == MK_IDLE)
			cnt_ff <= '0;
		else
			cnt_ff <= cnt_ff + CW'(1);
	end

	// mode is latched at the start so a mid-marker write cannot warp a phase
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
		begin
			adj_ff <= 1'b0;
			wide_ff <= 1'b0;
		end
		else if (state_ff == MK_IDLE && (i_start_sof || i_start_eof))
		begin
			adj_ff <= ctrl_ff.frame_marker_fine_adjust;
			wide_ff <= i_frame_marker_width_select;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			level_ff <= 1'b1;
		else
			level_ff <= nxt_level;
	end

	// ----------------------------------------------------------------
	// threshold shaping and self-test
	// ----------------------------------------------------------------
	rx_threshold_shaper u_shaper
	(
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_nonlinear(ctrl_ff.receiver_nonlinear_gain),
		.i_min_signal_level(i_min_signal_level),
		.i_collision_level(i_collision_level),
		.o_min_threshold(o_min_threshold),
		.o_collision_threshold(o_collision_threshold)
	);

	self_test_gate u_self_test
	(
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_self_test_select(ctrl_ff.self_test_select),
		.i_checksum_compute_command(i_checksum_compute_command),
		.o_self_test_enable(o_self_test_enable),
		.o_self_test_start(o_self_test_start)
	);

	assign o_rd_data = rd_data_ff;
	assign o_receiver_nonlinear_gain = ctrl_ff.receiver_nonlinear_gain;
	assign o_marker_busy = (state_ff != MK_IDLE);
	assign o_marker_level = level_ff;
	assign o_aux_one_source_select = aux_ff.aux_one_source_select;
	assign o_aux_two_source_select = aux_ff.aux_two_source_select;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// cycles the marker level has held its present value
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			hold_ff <= CW'(1);
		else if (nxt_level != level_ff)
			hold_ff <= CW'(1);
		else if (hold_ff != '1)
			hold_ff <= hold_ff + CW'(1);
	end

	property p_ctrl_reset;
		@(posedge i_clock)
		$fell(i_reset) |-> o_receiver_nonlinear_gain && !o_self_test_enable && rd_data_ff == 8'h00;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset value wrong");

	property p_gain_write;
		@(posedge i_clock) disable iff (i_reset)
		i_reg_req.wr && i_reg_req.addr == 8'h36
		|=> o_receiver_nonlinear_gain == $past(i_reg_req.wdata[6]);
	endproperty
	a_gain_write: assert property (p_gain_write) else $error("gain bit not written");

	property p_reserved_read;
		@(posedge i_clock) disable iff (i_reset)
		i_reg_req.rd && i_reg_req.addr == 8'h36 |=> o_rd_data[7] == 1'b0 && o_rd_data[5] == 1'b0;
	endproperty
	a_reserved_read: assert property (p_reserved_read) else $error("reserved bits read nonzero");

	property p_version_read;
		@(posedge i_clock) disable iff (i_reset)
		i_reg_req.rd && i_reg_req.addr == 8'h37 |=> o_rd_data == VERSION_CODE;
	endproperty
	a_version_read: assert property (p_version_read) else $error("version read wrong");

	property p_aux_write;
		@(posedge i_clock) disable iff (i_reset)
		i_reg_req.wr && i_reg_req.addr == 8'h38
		|=> o_aux_one_source_select == $past(i_reg_req.wdata[7:4])
			&& o_aux_two_source_select == $past(i_reg_req.wdata[3:0]);
	endproperty
	a_aux_write: assert property (p_aux_write) else $error("aux nibbles wrong");

	property p_self_test_enable;
		@(posedge i_clock) disable iff (i_reset)
		i_reg_req.wr && i_reg_req.addr == 8'h36
		|=> ##1 o_self_test_enable == ($past(i_reg_req.wdata[3:0], 2) == 4'h9);
	endproperty
	a_self_test_enable: assert property (p_self_test_enable) else $error("self-test enable wrong");

	property p_self_test_start;
		@(posedge i_clock) disable iff (i_reset)
		i_checksum_compute_command |=> o_self_test_start == $past(o_self_test_enable);
	endproperty
	a_self_test_start: assert property (p_self_test_start) else $error("self-test start wrong");

	property p_low_max;
		@(posedge i_clock) disable iff (i_reset)
		!level_ff && phase_end && wide_ff && !adj_ff |-> hold_ff == CW'(11 * ETU_CYCLES);
	endproperty
	a_low_max: assert property (p_low_max) else $error("maximum low phase length wrong");

	property p_low_min;
		@(posedge i_clock) disable iff (i_reset)
		!level_ff && phase_end && !wide_ff |-> hold_ff == CW'(10 * ETU_CYCLES);
	endproperty
	a_low_min: assert property (p_low_min) else $error("minimum low phase length wrong");

	property p_high_adj;
		@(posedge i_clock) disable iff (i_reset)
		state_ff == MK_SOF_HIGH && phase_end && wide_ff && adj_ff
		|-> hold_ff == CW'(2 * ETU_CYCLES + 8) ##1 !o_marker_busy;
	endproperty
	a_high_adj: assert property (p_high_adj) else $error("adjusted high phase length wrong");

	property p_low_adj;
		@(posedge i_clock) disable iff (i_reset)
		!level_ff && phase_end && wide_ff && adj_ff |-> hold_ff == CW'(11 * ETU_CYCLES - 8);
	endproperty
	a_low_adj: assert property (p_low_adj) else $error("adjusted low phase length wrong");

	property p_sof_start;
		@(posedge i_clock) disable iff (i_reset)
		!o_marker_busy && i_start_sof |=> o_marker_busy && !o_marker_level;
	endproperty
	a_sof_start: assert property (p_sof_start) else $error("start marker did not begin low");

	c_self_test_start: cover property (@(posedge i_clock) disable iff (i_reset) o_self_test_start);
	c_adj_sof_done: cover property (@(posedge i_clock) disable iff (i_reset)
		state_ff == MK_SOF_HIGH && phase_end && adj_ff && wide_ff);
	c_eof_done: cover property (@(posedge i_clock) disable iff (i_reset)
		state_ff == MK_EOF_LOW && phase_end);
	c_version_read: cover property (@(posedge i_clock) disable iff (i_reset)
		i_reg_req.rd && i_reg_req.addr == 8'h37);
endmodule

// ===== include/test_regs_pkg.sv
/*
 * Package for the test-page register bank: offsets, reset values, field
 * positions, self-test codes, frame marker timing figures and carriers.
 * Assumes a 100 MHz system clock and 8-bit register data.
 */
package test_regs_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] SELF_TEST_CONTROL_OFFSET = 8'h36;
	localparam logic [7:0] SILICON_VERSION_OFFSET = 8'h37;
	localparam logic [7:0] AUX_PIN_SOURCE_SELECT_OFFSET = 8'h38;
	localparam logic [7:0] SELF_TEST_CONTROL_RESET = 8'h40;
	localparam logic [7:0] AUX_PIN_SOURCE_SELECT_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// ----------------------------------------------------------------
	// self-test control fields
	// ----------------------------------------------------------------
	localparam int GAIN_BIT = 6;
	localparam int FINE_ADJUST_BIT = 4;
	localparam int RESERVED_HI_BIT = 7;
	localparam int RESERVED_LO_BIT = 5;
	localparam logic [3:0] SELF_TEST_ENABLE_CODE = 4'h9;
	localparam logic [3:0] SELF_TEST_DISABLE_CODE = 4'h0;

	// ----------------------------------------------------------------
	// frame marker timing
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_PS = 10000;
	localparam int ETU_PS = 9439500;
	localparam int ETU_CYCLES_DEFAULT = ETU_PS / CLOCK_PERIOD_PS;
	localparam int SOF_LOW_MIN_ETU = 10;
	localparam int SOF_LOW_MAX_ETU = 11;
	localparam int SOF_HIGH_MIN_ETU = 2;
	localparam int SOF_HIGH_MAX_ETU = 3;
	localparam int ADJUST_CYCLES = 8;
	localparam int PHASE_COUNT_WIDTH = 16;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic reserved_hi;
		logic receiver_nonlinear_gain;
		logic reserved_lo;
		logic frame_marker_fine_adjust;
		logic [3:0] self_test_select;
	} self_test_control_t;

	typedef struct packed {
		logic [3:0] aux_one_source_select;
		logic [3:0] aux_two_source_select;
	} aux_select_t;

endpackage

// ===== verilog/rx_threshold_shaper.sv
/*
 * Shapes the receive threshold codes into effective threshold levels,
 * linearly or as a square law when non-linear gain is on.
 * Assumes the threshold codes come from logic on the same clock.
 */
`timescale 1ns/1ps
module rx_threshold_shaper
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_nonlinear,
	input wire logic [3:0] i_min_signal_level,
	input wire logic [2:0] i_collision_level,
	output logic [7:0] o_min_threshold,
	output logic [7:0] o_collision_threshold
);
	logic [7:0] min_thr_ff;
	logic [7:0] coll_thr_ff;
	logic [7:0] coll_sq;

	// square law keeps small codes fine-grained, matching the gain curve
	function automatic logic [7:0] square4(input logic [3:0] x);
		logic [7:0] w;
		w = {4'h0, x};
		return 8'(w * w);
	endfunction

	// a 3-bit code squares to at most 49, so six bits carry it
	assign coll_sq = square4({1'b0, i_collision_level});

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			min_thr_ff <= 8'h00;
		else if (i_nonlinear)
			min_thr_ff <= square4(i_min_signal_level);
		else
			min_thr_ff <= {i_min_signal_level, 4'h0};
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			coll_thr_ff <= 8'h00;
		else if (i_nonlinear)
			coll_thr_ff <= {coll_sq[5:0], 2'b00};
		else
			coll_thr_ff <= {i_collision_level, 5'h00};
	end

	assign o_min_threshold = min_thr_ff;
	assign o_collision_threshold = coll_thr_ff;

	property p_nonlinear_min;
		@(posedge i_clock) disable iff (i_reset)
		i_nonlinear |=> o_min_threshold
			== {4'h0, $past(i_min_signal_level)} * {4'h0, $past(i_min_signal_level)};
	endproperty
	a_nonlinear_min: assert property (p_nonlinear_min) else $error("min threshold not square");

	property p_nonlinear_coll;
		@(posedge i_clock) disable iff (i_reset)
		i_nonlinear |=> o_collision_threshold[1:0] == 2'b00 && o_collision_threshold
			== 8'(4 * $past(i_collision_level) * $past(i_collision_level));
	endproperty
	a_nonlinear_coll: assert property (p_nonlinear_coll) else $error("collision threshold wrong");
endmodule

// ===== verilog/self_test_gate.sv
/*
 * Self-test gate: decodes the select field into an enable level and
 * turns a checksum command into a self-test start pulse.
 * Assumes the command is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
module self_test_gate
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [3:0] i_self_test_select,
	input wire logic i_checksum_compute_command,
	output logic o_self_test_enable,
	output logic o_self_test_start
);
	logic enable_ff;
	logic start_ff;

	// only the exact pattern enables; any other code keeps the test off
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			enable_ff <= 1'b0;
		else
			enable_ff <= (i_self_test_select == test_regs_pkg::SELF_TEST_ENABLE_CODE);
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
			start_ff <= 1'b0;
		else
			start_ff <= i_checksum_compute_command && enable_ff;
	end

	assign o_self_test_enable = enable_ff;
	assign o_self_test_start = start_ff;
endmodule

// ===== verif/test_test_config_version_regs.sv
/*
 * Self-checking bench for the test-page register bank: register map, reserved
 * bits, self-test gating, threshold shaping and type B frame marker lengths.
 * Assumes the design's plain register port and a short ETU so markers stay brief.
 */
`timescale 1ns/1ps
module test_test_config_version_regs;
	localparam int ETU = 16;
	localparam logic [7:0] VER = 8'hC3; // arbitrary value
	logic clock;
	logic reset;
	test_regs_pkg::reg_req_t req;
	logic width;
	logic sof;
	logic eof;
	logic cmd;
	logic [3:0] minl;
	logic [2:0] coll;
	logic [7:0] rd_data;
	logic gain;
	logic [7:0] min_thr;
	logic [7:0] coll_thr;
	logic busy;
	logic level;
	logic st_en;
	logic st_start;
	logic [3:0] aux_one;
	logic [3:0] aux_two;
	int n_fail = 0;
	int cmp_count = 0;

	test_config_version_regs #(.ETU_CYCLES(ETU), .VERSION_CODE(VER)) i_dut
	(
		.i_clock(clock), .i_reset(reset), .i_reg_req(req), .o_rd_data(rd_data),
		.i_frame_marker_width_select(width), .i_start_sof(sof), .i_start_eof(eof),
		.i_checksum_compute_command(cmd), .i_min_signal_level(minl),
		.i_collision_level(coll), .o_receiver_nonlinear_gain(gain),
		.o_min_threshold(min_thr), .o_collision_threshold(coll_thr),
		.o_marker_busy(busy), .o_marker_level(level), .o_self_test_enable(st_en),
		.o_self_test_start(st_start), .o_aux_one_source_select(aux_one),
		.o_aux_two_source_select(aux_two)
	);

	// ----------------------------------------------------------------
	// clock, compare and verdict
	// ----------------------------------------------------------------
	always #5 clock = ~clock;

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: byte got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: flag got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		cmp_count++;
		if (got != exp)
		begin
			n_fail++;
			$display("Error at %0t: length got %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic results;
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// register port and pulse drivers
	// ----------------------------------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clock);
		req.wr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clock);
		req.rd <= 1'b0;
		#1;
		chk8(rd_data, exp);
	endtask

	task automatic command_chk(input logic exp);
		@(posedge clock);
		cmd <= 1'b1;
		@(posedge clock);
		cmd <= 1'b0;
		#1;
		chk1(st_start, exp);
		@(posedge clock);
		#1;
		chk1(st_start, 1'b0);
	endtask

	// counts low cycles, then high cycles while busy; bounded so a stuck marker ends
	task automatic marker_chk(input logic is_sof, input int exp_low, input int exp_high);
		int k;
		int lo;
		int hi;
		k = 0;
		lo = 0;
		hi = 0;
		@(posedge clock);
		sof <= is_sof;
		eof <= ~is_sof;
		@(posedge clock);
		sof <= 1'b0;
		eof <= 1'b0;
		#1;
		while (busy !== 1'b1 && k < 3)
		begin
			k++;
			@(posedge clock);
			#1;
		end
		while (busy === 1'b1 && level === 1'b0 && lo < 1000)
		begin
			lo++;
			@(posedge clock);
			#1;
		end
		while (busy === 1'b1 && level === 1'b1 && hi < 1000)
		begin
			hi++;
			@(posedge clock);
			#1;
		end
		chk_n(lo, exp_low);
		chk_n(hi, exp_high);
		chk1(busy, 1'b0);
		chk1(level, 1'b1);
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		#30000;
		n_fail++;
		results();
	end

	initial
	begin
		clock = 1'b0;
		reset = 1'b1;
		req = '0;
		width = 1'b0;
		sof = 1'b0;
		eof = 1'b0;
		cmd = 1'b0;
		minl = 4'hF;
		coll = 3'h7;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		rd_chk(8'h36, 8'h40);
		rd_chk(8'h37, VER);
		rd_chk(8'h38, 8'h00);
		rd_chk(8'h3A, 8'h00);
		chk1(gain, 1'b1);
		chk8(min_thr, 8'hE1);
		chk8(coll_thr, 8'hC4);
		wr_reg(8'h36, 8'hFF);
		rd_chk(8'h36, 8'h5F);
		wr_reg(8'h37, 8'h00);
		rd_chk(8'h37, VER);
		wr_reg(8'h38, 8'hA5);
		chk8({aux_one, aux_two}, 8'hA5);
		rd_chk(8'h38, 8'hA5);
		@(posedge clock);
		minl <= 4'h3;
		coll <= 3'h3;
		wr_reg(8'h36, 8'h00);
		chk1(gain, 1'b0);
		repeat (2) @(posedge clock);
		#1;
		chk8(min_thr, 8'h30);
		chk8(coll_thr, 8'h60);
		// self-test gating, enable trails the select field by a cycle
		wr_reg(8'h36, 8'h09);
		repeat (2) @(posedge clock);
		#1;
		chk1(st_en, 1'b1);
		command_chk(1'b1);
		wr_reg(8'h36, 8'h08);
		repeat (2) @(posedge clock);
		#1;
		chk1(st_en, 1'b0);
		command_chk(1'b0);
		wr_reg(8'h36, 8'h09);
		wr_reg(8'h36, 8'h00);
		repeat (2) @(posedge clock);
		#1;
		chk1(st_en, 1'b0);
		// frame markers in the three modes
		marker_chk(1'b1, 10 * ETU, 2 * ETU);
		marker_chk(1'b0, 10 * ETU, 0);
		@(posedge clock);
		width <= 1'b1;
		marker_chk(1'b1, 11 * ETU, 3 * ETU);
		marker_chk(1'b0, 11 * ETU, 0);
		wr_reg(8'h36, 8'h10);
		marker_chk(1'b1, 11 * ETU - 8, 2 * ETU + 8);
		marker_chk(1'b0, 11 * ETU - 8, 0);
		// fine adjust without width select falls back to the minimum lengths
		@(posedge clock);
		width <= 1'b0;
		marker_chk(1'b0, 10 * ETU, 0);
		results();
	end
endmodule
